// ---- logic/cfg_loader_defines.svh ----
`ifndef CFG_LOADER_DEFINES_SVH
`define CFG_LOADER_DEFINES_SVH

// Device register offsets
`define A_SOFT_RESET   16'h001C
`define A_HARD_RESET   16'h001E
`define A_ACTIVE_BANK  16'h00E2
`define A_NVM_PROGRAM  16'h00E3
`define A_NVM_DOWNLOAD 16'h00E4
`define A_READY_LOW    8'hFE
`define A_BUS_ADDR     16'h000B
`define A_IN_DIV_UPD   16'h0230
`define A_XTAL_DIV_UPD 16'h023F
`define A_GUARD1       16'h0B24
`define A_GUARD2       16'h0B25
`define A_GUARD3       16'h0540
`define A_SCRATCH_LO   16'h026B
`define A_SCRATCH_HI   16'h0272

// Field positions
`define HARD_BIT       1
`define SOFT_BIT       0
`define DOWNLOAD_BIT   0

// Codes and values
`define PROG_KEY       8'hC7
`define READY_CODE     8'h0F
`define BUSY_CODE      8'h00
`define SOFT_KEY       8'h01
`define DOWNLOAD_KEY   8'h01
`define PRE_G1         8'hC0
`define PRE_G2         8'h00
`define PRE_G3         8'h01
`define POST_G3        8'h00
`define POST_G1        8'hC3
`define POST_G2        8'h02
`define FACTORY_BUS_ADDR 8'h5A
`define USER_BANKS     2'h2

// Shadow indices and timing counts
`define IDX_BUS        4'h0
`define IDX_IN_DIV     4'h1
`define IDX_XTAL_DIV   4'h2
`define CFG_LAST       8'h0F
`define INIT_CYCLES    8'h20
`define PROG_CYCLES    8'h40
`define CLK_MHZ        100
`define SETTLE_MS      300
`define SETTLE_CYCLES  (`SETTLE_MS * 1000 * `CLK_MHZ)
`define PIN_CYCLES     32'h4

// Host Wishbone offsets
`define WB_CMD         4'h0
`define WB_ADDR        4'h4
`define WB_WDATA       4'h8
`define WB_STATUS      4'hC

`endif

// ---- logic/cfg_loader_pkg.sv ----
`default_nettype none

package cfg_loader_pkg;

	typedef enum logic [2:0] {
		S_LOAD = 3'b000,
		S_INIT = 3'b001,
		S_RUN  = 3'b010,
		S_PROG = 3'b011
	} dev_state_t;

	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_FETCH = 3'b001,
		H_ISSUE = 3'b010,
		H_WAIT  = 3'b011,
		H_PULSE = 3'b100
	} host_state_t;

	typedef enum logic [2:0] {
		OP_END   = 3'b000,
		OP_RD    = 3'b001,
		OP_WR    = 3'b010,
		OP_POLL  = 3'b011,
		OP_WAIT  = 3'b100,
		OP_PULSE = 3'b101
	} host_op_t;

	typedef enum logic [2:0] {
		CMD_READ     = 3'b000,
		CMD_WRITE    = 3'b001,
		CMD_PREAMBLE = 3'b010,
		CMD_POSTAMBLE= 3'b011,
		CMD_NVM_LOAD = 3'b100,
		CMD_NVM_HARD = 3'b101,
		CMD_PIN      = 3'b110
	} host_cmd_t;

	typedef struct packed {
		host_op_t    op;
		logic [15:0] addr;
		logic [7:0]  data;
	} step_t;

endpackage

`default_nettype wire

// ---- logic/cfg_link_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface cfg_link_if (
	input wire logic clk
);
	logic        req;
	logic        we;
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        ack;
	logic        reset_pin_n;

	modport dev (
		input  clk, req, we, addr, wdata, reset_pin_n,
		output rdata, ack
	);
	modport host (
		input  clk, rdata, ack,
		output req, we, addr, wdata, reset_pin_n
	);
endinterface

`default_nettype wire

// ---- logic/cfg_loader_device.sv ----
// Chosen here: the req/ack link register port.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_loader_defines.svh"

module cfg_loader_device (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// Link to the host controller
	cfg_link_if.dev         link,
	// Clock path controls
	output logic            clk_out_en_out,
	output logic            freerun_out,
	output logic            soft_reset_out,
	output logic [7:0]      in_div_update_out,
	output logic [7:0]      xtal_div_update_out
);
	import cfg_loader_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Storage

	logic [7:0]  cfg_reg  [0:15];
	logic [7:0]  nvm_mem  [0:1][0:15];
	dev_state_t  state_reg;
	dev_state_t  state_next;
	logic [7:0]  cnt_reg;
	logic [7:0]  cnt_next;
	logic        hard_reg;
	logic        hard_next;
	logic        en_reg;
	logic        en_next;
	logic [1:0]  writes_reg;
	logic        pin_s1_reg;
	logic        pin_s2_reg;
	logic        ack_reg;
	logic [7:0]  rdata_reg;
	logic        soft_reg;
	logic [7:0]  in_div_reg;
	logic [7:0]  xtal_div_reg;

	////////////////////////////////////////////////////////////////////////////
	// Decoding

	// Maps a register address to a shadow slot, bit 4 marks a hit
	function automatic logic [4:0] map_f(input logic [15:0] a);
		logic [15:0] off;
		off = a - `A_SCRATCH_LO;
		if (a == `A_BUS_ADDR) map_f = {1'b1, `IDX_BUS};
		else if (a == `A_IN_DIV_UPD) map_f = {1'b1, `IDX_IN_DIV};
		else if (a == `A_XTAL_DIV_UPD) map_f = {1'b1, `IDX_XTAL_DIV};
		else if (a == `A_GUARD1) map_f = 5'h13;
		else if (a == `A_GUARD2) map_f = 5'h14;
		else if (a == `A_GUARD3) map_f = 5'h15;
		else if (a >= `A_SCRATCH_LO && a <= `A_SCRATCH_HI) map_f = {2'b11, off[2:0]};
		else map_f = 5'h00;
	endfunction

	// Factory bank: all zero except the serial bus address
	function automatic logic [7:0] factory_f(input logic [3:0] idx);
		factory_f = (idx == `IDX_BUS) ? `FACTORY_BUS_ADDR : 8'h00;
	endfunction

	wire logic [4:0] slot     = map_f(link.addr);
	wire logic       take     = link.req && !ack_reg && !hard_reg;
	wire logic       wr_run   = take && link.we && (state_reg == S_RUN);
	wire logic       hard_req = !pin_s2_reg
		|| (wr_run && link.addr == `A_HARD_RESET && link.wdata[`HARD_BIT]);
	wire logic       soft_req = wr_run && link.addr == `A_SOFT_RESET
		&& link.wdata[`SOFT_BIT];
	wire logic       prog_req = wr_run && link.addr == `A_NVM_PROGRAM
		&& link.wdata == `PROG_KEY && writes_reg < `USER_BANKS;
	wire logic       load_req = wr_run && link.addr == `A_NVM_DOWNLOAD
		&& link.wdata[`DOWNLOAD_BIT];
	wire logic [3:0] idx      = cnt_reg[3:0];
	wire logic [7:0] load_val = (idx == `IDX_BUS || writes_reg == 2'h0) ? factory_f(idx)
		: nvm_mem[writes_reg[1] ? 1 : 0][idx];
	wire logic [7:0] ready_val = (state_reg == S_RUN) ? `READY_CODE : `BUSY_CODE;

	// Read mux; ready answers whatever page the high byte selects
	logic [7:0] rd_val;
	always_comb
	begin
		if (link.addr[7:0] == `A_READY_LOW)
			rd_val = ready_val;
		else if (link.addr == `A_ACTIVE_BANK)
			rd_val = {6'h00, writes_reg};
		else if (slot[4])
			rd_val = cfg_reg[slot[3:0]];
		else
			rd_val = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	// Hard reset wins over every state, just like a power cycle
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		hard_next = hard_reg;
		en_next = en_reg;
		if (hard_req)
		begin
			state_next = S_LOAD;
			cnt_next = 8'h00;
			hard_next = 1'b1;
			en_next = 1'b0;
		end
		else
		begin
			case (state_reg)
				S_LOAD:
				begin
					cnt_next = (cnt_reg == `CFG_LAST) ? 8'h00 : cnt_reg + 8'h01;
					if (cnt_reg == `CFG_LAST)
						state_next = S_INIT;
				end
				S_INIT:
				begin
					cnt_next = cnt_reg + 8'h01;
					if (cnt_reg == `INIT_CYCLES - 8'h01)
					begin
						state_next = S_RUN;
						cnt_next = 8'h00;
						hard_next = 1'b0;
						en_next = 1'b1;
					end
				end
				S_RUN:
				begin
					if (prog_req)
						state_next = S_PROG;
					else if (load_req)
						state_next = S_LOAD;
				end
				S_PROG:
				begin
					cnt_next = cnt_reg + 8'h01;
					if (cnt_reg == `PROG_CYCLES - 8'h01)
					begin
						state_next = S_RUN;
						cnt_next = 8'h00;
					end
				end
				default:
					state_next = S_LOAD;
			endcase
		end
	end

	// Sequencer registers; the reset pin is asynchronous to us, so it passes two
	// flops and only the second one is read
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= S_LOAD;
			cnt_reg <= 8'h00;
			hard_reg <= 1'b1;
			en_reg <= 1'b0;
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			hard_reg <= hard_next;
			en_reg <= en_next;
			pin_s1_reg <= link.reset_pin_n;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register shadow and NVM

	// Shadow is filled from NVM while loading, else by host writes
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < 16; i++)
				cfg_reg[i] <= 8'h00;
		end
		else if (state_reg == S_LOAD && !hard_req)
			cfg_reg[idx] <= load_val;
		else if (wr_run && slot[4])
			cfg_reg[slot[3:0]] <= link.wdata;
	end

	// Each program burns the next bank; a third attempt is refused above
	always_ff @(posedge clk_in)
	begin
		if (state_reg == S_PROG && cnt_reg <= `CFG_LAST && idx != `IDX_BUS)
			nvm_mem[writes_reg[0] ? 1 : 0][idx] <= cfg_reg[idx];
	end

	// Burn count survives hard resets; only power-on clears it
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			writes_reg <= 2'h0;
		else if (state_reg == S_PROG && cnt_reg == `PROG_CYCLES - 8'h01 && !hard_req)
			writes_reg <= writes_reg + 2'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Link answer and soft reset

	// One-cycle ack, silent during the load and init after power-on or a hard reset, or a pin reset; the hard bit write is
	// still answered, else its sender would hold it and reset us again forever.
	// Soft reset latches pending divider updates, no NVM traffic
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 8'h00;
			soft_reg <= 1'b0;
			in_div_reg <= 8'h00;
			xtal_div_reg <= 8'h00;
		end
		else
		begin
			ack_reg <= take && pin_s2_reg;
			soft_reg <= soft_req;
			if (take)
				rdata_reg <= rd_val;
			if (soft_req)
			begin
				in_div_reg <= cfg_reg[`IDX_IN_DIV];
				xtal_div_reg <= cfg_reg[`IDX_XTAL_DIV];
			end
		end
	end

	assign link.ack = ack_reg;
	assign link.rdata = rdata_reg;
	assign clk_out_en_out = en_reg;
	assign freerun_out = en_reg;
	assign soft_reset_out = soft_reg;
	assign in_div_update_out = in_div_reg;
	assign xtal_div_update_out = xtal_div_reg;
endmodule

`default_nettype wire

// ---- logic/cfg_loader_host.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cfg_loader_defines.svh"

module cfg_loader_host #(
	parameter int unsigned SETTLE_CYCLES = `SETTLE_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Wishbone slave
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [3:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic [31:0]      wb_dat_out,
	output logic             wb_ack_out,
	// Link to the device
	cfg_link_if.host         link
);
	import cfg_loader_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Command scripts

	function automatic step_t mk(input host_op_t op, input logic [15:0] a,
		input logic [7:0] d);
		mk = '{op: op, addr: a, data: d};
	endfunction

	// Guard updates are read-modify-write: read, then write the new value
	function automatic step_t step_f(input host_cmd_t c, input logic [3:0] pc,
		input logic [15:0] a, input logic [7:0] d);
		step_f = mk(OP_END, 16'h0000, 8'h00);
		case (c)
			CMD_READ:      if (pc == 4'h0) step_f = mk(OP_RD, a, d);
			CMD_WRITE:     if (pc == 4'h0) step_f = mk(OP_WR, a, d);
			CMD_PREAMBLE:
				case (pc)
					4'h0: step_f = mk(OP_RD, `A_GUARD1, 8'h00);
					4'h1: step_f = mk(OP_WR, `A_GUARD1, `PRE_G1);
					4'h2: step_f = mk(OP_RD, `A_GUARD2, 8'h00);
					4'h3: step_f = mk(OP_WR, `A_GUARD2, `PRE_G2);
					4'h4: step_f = mk(OP_RD, `A_GUARD3, 8'h00);
					4'h5: step_f = mk(OP_WR, `A_GUARD3, `PRE_G3);
					4'h6: step_f = mk(OP_WAIT, 16'h0000, 8'h00);
					default: step_f = mk(OP_END, 16'h0000, 8'h00);
				endcase
			CMD_POSTAMBLE:
				case (pc)
					4'h0: step_f = mk(OP_WR, `A_SOFT_RESET, `SOFT_KEY);
					4'h1: step_f = mk(OP_RD, `A_GUARD3, 8'h00);
					4'h2: step_f = mk(OP_WR, `A_GUARD3, `POST_G3);
					4'h3: step_f = mk(OP_RD, `A_GUARD1, 8'h00);
					4'h4: step_f = mk(OP_WR, `A_GUARD1, `POST_G1);
					4'h5: step_f = mk(OP_RD, `A_GUARD2, 8'h00);
					4'h6: step_f = mk(OP_WR, `A_GUARD2, `POST_G2);
					default: step_f = mk(OP_END, 16'h0000, 8'h00);
				endcase
			CMD_NVM_LOAD, CMD_NVM_HARD:
				case (pc)
					4'h0: step_f = mk(OP_WR, `A_NVM_PROGRAM, `PROG_KEY);
					4'h1: step_f = mk(OP_POLL, {8'h00, `A_READY_LOW}, 8'h00);
					4'h2: step_f = (c == CMD_NVM_HARD)
						? mk(OP_PULSE, 16'h0000, 8'h00)
						: mk(OP_WR, `A_NVM_DOWNLOAD, `DOWNLOAD_KEY);
					4'h3: step_f = mk(OP_POLL, {8'h00, `A_READY_LOW}, 8'h00);
					default: step_f = mk(OP_END, 16'h0000, 8'h00);
				endcase
			CMD_PIN:       if (pc == 4'h0) step_f = mk(OP_PULSE, 16'h0000, 8'h00);
			default:       step_f = mk(OP_END, 16'h0000, 8'h00);
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Registers

	host_state_t st_reg;
	host_cmd_t   cmd_reg;
	logic [3:0]  pc_reg;
	logic [15:0] tgt_addr_reg;
	logic [7:0]  tgt_data_reg;
	logic [7:0]  rdata_reg;
	logic [31:0] wait_reg;
	logic        req_reg;
	logic        we_reg;
	logic [15:0] laddr_reg;
	logic [7:0]  lwdata_reg;
	logic        pin_n_reg;
	logic        wb_ack_reg;

	wire step_t  cur     = step_f(cmd_reg, pc_reg, tgt_addr_reg, tgt_data_reg);
	wire logic   busy    = (st_reg != H_IDLE);
	wire logic   wb_hit  = wb_cyc_in && wb_stb_in && !wb_ack_reg;
	wire logic   wb_wr   = wb_hit && wb_we_in && !busy;
	wire logic   start   = wb_wr && wb_adr_in == `WB_CMD && wb_sel_in[0];
	wire logic   again   = cur.op == OP_POLL && link.rdata != `READY_CODE;

	// Wishbone read mux
	always_comb
	begin
		if (wb_adr_in == `WB_CMD)
			wb_dat_out = {29'h0, cmd_reg};
		else if (wb_adr_in == `WB_ADDR)
			wb_dat_out = {16'h0, tgt_addr_reg};
		else if (wb_adr_in == `WB_WDATA)
			wb_dat_out = {24'h0, tgt_data_reg};
		else if (wb_adr_in == `WB_STATUS)
			wb_dat_out = {23'h0, busy, rdata_reg};
		else
			wb_dat_out = 32'h0;
	end

	// Wishbone ack and operand registers; writes while busy are dropped
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wb_ack_reg <= 1'b0;
			tgt_addr_reg <= 16'h0000;
			tgt_data_reg <= 8'h00;
		end
		else
		begin
			wb_ack_reg <= wb_hit;
			if (wb_wr && wb_adr_in == `WB_ADDR && wb_sel_in[0])
				tgt_addr_reg[7:0] <= wb_dat_in[7:0];
			if (wb_wr && wb_adr_in == `WB_ADDR && wb_sel_in[1])
				tgt_addr_reg[15:8] <= wb_dat_in[15:8];
			if (wb_wr && wb_adr_in == `WB_WDATA && wb_sel_in[0])
				tgt_data_reg <= wb_dat_in[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Script engine; a poll issues only ready reads until the code shows

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_reg <= H_IDLE;
			cmd_reg <= CMD_READ;
			pc_reg <= 4'h0;
			rdata_reg <= 8'h00;
			wait_reg <= 32'h0;
			req_reg <= 1'b0;
			we_reg <= 1'b0;
			laddr_reg <= 16'h0000;
			lwdata_reg <= 8'h00;
			pin_n_reg <= 1'b1;
		end
		else
		begin
			case (st_reg)
				H_IDLE:
					if (start)
					begin
						cmd_reg <= host_cmd_t'(wb_dat_in[2:0]);
						pc_reg <= 4'h0;
						st_reg <= H_FETCH;
					end
				H_FETCH:
					case (cur.op)
						OP_RD, OP_WR, OP_POLL:
						begin
							req_reg <= 1'b1;
							we_reg <= (cur.op == OP_WR);
							laddr_reg <= cur.addr;
							lwdata_reg <= cur.data;
							st_reg <= H_ISSUE;
						end
						OP_WAIT:
						begin
							wait_reg <= 32'h0;
							st_reg <= H_WAIT;
						end
						OP_PULSE:
						begin
							wait_reg <= 32'h0;
							pin_n_reg <= 1'b0;
							st_reg <= H_PULSE;
						end
						default:
							st_reg <= H_IDLE;
					endcase
				H_ISSUE:
					if (link.ack)
					begin
						req_reg <= 1'b0;
						rdata_reg <= link.rdata;
						pc_reg <= again ? pc_reg : pc_reg + 4'h1;
						st_reg <= H_FETCH;
					end
				H_WAIT:
				begin
					wait_reg <= wait_reg + 32'h1;
					if (wait_reg == SETTLE_CYCLES - 32'h1)
					begin
						pc_reg <= pc_reg + 4'h1;
						st_reg <= H_FETCH;
					end
				end
				H_PULSE:
				begin
					wait_reg <= wait_reg + 32'h1;
					if (wait_reg == `PIN_CYCLES - 32'h1)
					begin
						pin_n_reg <= 1'b1;
						pc_reg <= pc_reg + 4'h1;
						st_reg <= H_FETCH;
					end
				end
				default:
					st_reg <= H_IDLE;
			endcase
		end
	end

	assign wb_ack_out = wb_ack_reg;
	assign link.req = req_reg;
	assign link.we = we_reg;
	assign link.addr = laddr_reg;
	assign link.wdata = lwdata_reg;
	assign link.reset_pin_n = pin_n_reg;
endmodule

`default_nettype wire

// ---- sim/reset_and_nvm_config_control_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none

module reset_and_nvm_config_control_asserts (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n_in,
	// Link signals
	input wire logic        req,
	input wire logic        we,
	input wire logic [15:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic [7:0]  rdata,
	input wire logic        ack,
	input wire logic        reset_pin_n,
	// Device clock path outputs
	input wire logic        clk_out_en_out,
	input wire logic        freerun_out,
	input wire logic        soft_reset_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n_in);

	////////////////////////////////////////////////////////////////////////////////////////
	// Cycles since power-on release; saturates so a long run never wraps
	logic [7:0] since_rst_reg;
	logic [7:0] since_rst_next;
	assign since_rst_next = (since_rst_reg == 8'hFF) ? since_rst_reg : since_rst_reg + 8'h01;

	// Counter of the load and init window
	always_ff @(posedge clk or negedge rst_n_in)
	begin
		if (!rst_n_in)
			since_rst_reg <= 8'h00;
		else
			since_rst_reg <= since_rst_next;
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Link answers and host holding
	a_no_early_ack: assert property (ack |-> since_rst_reg >= 8'h2D)
		else $error("link answered during power-on init");
	a_ack_one_pulse: assert property (ack |=> !ack)
		else $error("link ack longer than one cycle");
	a_ack_has_req: assert property (ack |-> req && $past(req))
		else $error("link ack without a held request");
	a_req_held_stable: assert property (req && !ack |=> req && $stable(addr) && $stable(we)
		&& $stable(wdata))
		else $error("host changed request before ack");

	// Ready code and clock outputs
	a_clk_off_init: assert property (since_rst_reg < 8'h2E |-> !clk_out_en_out)
		else $error("output clocks on before init completed");
	a_ready_code_set: assert property (ack && !we && addr[7:0] == 8'hFE
		|-> rdata == 8'h0F || rdata == 8'h00)
		else $error("ready status read an unexpected code");
	a_ready_in_run: assert property (ack && !we && addr[7:0] == 8'hFE && rdata == 8'h0F
		|-> clk_out_en_out)
		else $error("ready code read while not running");
	a_freerun_tied: assert property (freerun_out == clk_out_en_out)
		else $error("free-run and clock enable disagree");

	// Resets
	a_pin_drops_clk: assert property ($fell(reset_pin_n) |-> ##[1:6] !clk_out_en_out)
		else $error("reset pin did not stop the clocks");
	a_pin_pulse_len: assert property ($fell(reset_pin_n) |-> !reset_pin_n[*4] ##1 reset_pin_n)
		else $error("reset pin pulse has wrong length");
	a_hard_bit_clk: assert property (ack && we && addr == 16'h001E && wdata[1]
		|-> ##[0:4] !clk_out_en_out)
		else $error("hard reset bit did not stop the clocks");
	a_soft_keeps_clk: assert property (soft_reset_out
		|-> clk_out_en_out ##1 (!soft_reset_out && clk_out_en_out))
		else $error("soft reset pulse long or clocks dropped");

	// Main scenarios seen
	c_ready_read: cover property (ack && !we && addr[7:0] == 8'hFE && rdata == 8'h0F);
	c_soft_reset: cover property (soft_reset_out);
	c_pin_reset: cover property ($fell(reset_pin_n));
	c_program: cover property (ack && we && addr == 16'h00E3 && wdata == 8'hC7);
endmodule

`default_nettype wire

// ---- sim/reset_and_nvm_config_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module reset_and_nvm_config_control_tb;
	import cfg_loader_pkg::*;
	// Drivers and observed outputs
	logic        clk_in;
	logic        rst_n_in;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [3:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat_w;
	logic [31:0] wb_dat_r;
	logic        wb_ack;
	logic        clk_out_en;
	logic        freerun;
	logic        soft_pulse;
	logic [7:0]  in_div;
	logic [7:0]  xtal_div;
	logic [31:0] rsp;
	int          miscompares;
	int          check_count;

	initial clk_in = 1'b0;
	always #5 clk_in = ~clk_in;

	////////////////////////////////////////////////////////////////////////////////////////
	// Both ends joined over the link; settle shortened to keep the run brief
	cfg_link_if u_cfg_link_if (.clk(clk_in));

	cfg_loader_device u_cfg_loader_device (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.link(u_cfg_link_if), .clk_out_en_out(clk_out_en), .freerun_out(freerun),
		.soft_reset_out(soft_pulse), .in_div_update_out(in_div), .xtal_div_update_out(xtal_div));

	cfg_loader_host #(.SETTLE_CYCLES(50)) u_cfg_loader_host (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
		.wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat_w), .wb_dat_out(wb_dat_r),
		.wb_ack_out(wb_ack), .link(u_cfg_link_if));

	reset_and_nvm_config_control_asserts u_asserts (.clk(clk_in), .rst_n_in(rst_n_in),
		.req(u_cfg_link_if.req), .we(u_cfg_link_if.we), .addr(u_cfg_link_if.addr),
		.wdata(u_cfg_link_if.wdata), .rdata(u_cfg_link_if.rdata), .ack(u_cfg_link_if.ack),
		.reset_pin_n(u_cfg_link_if.reset_pin_n), .clk_out_en_out(clk_out_en),
		.freerun_out(freerun), .soft_reset_out(soft_pulse));

	////////////////////////////////////////////////////////////////////////////////////////
	// Verdict, the single exit of the run
	task automatic summarize;
		$display("Checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Classic single Wishbone cycle; the answer is taken only at the ack edge
	task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
		input logic [31:0] dat);
		int n;
		@(posedge clk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= sel;
		wb_dat_w <= dat;
		for (n = 0; n < 50 && wb_ack !== 1'b1; n++)
			@(posedge clk_in);
		if (n == 50)
		begin
			chk("wb_ack", 32'h1, 32'h0);
			summarize();
		end
		rsp = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	// Load address and data, start a script, poll busy under a bound
	task automatic host_cmd(input host_cmd_t cmd, input logic [15:0] a, input logic [7:0] d);
		int n;
		wb(1'b1, 4'h4, 4'h3, {16'h0000, a});
		wb(1'b1, 4'h8, 4'h1, {24'h000000, d});
		wb(1'b1, 4'h0, 4'h1, {29'h00000000, cmd});
		for (n = 0; n < 20000; n++)
		begin
			wb(1'b0, 4'hC, 4'hF, 32'h00000000);
			if (rsp[8] === 1'b0)
				break;
		end
		if (n == 20000)
		begin
			chk("host busy", 32'h0, 32'h1);
			summarize();
		end
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
		host_cmd(CMD_READ, a, 8'h00);
		chk(name, {24'h000000, exp}, {24'h000000, rsp[7:0]});
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		host_cmd(CMD_WRITE, a, d);
	endtask

	////////////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_power_up;
		repeat (10) @(posedge clk_in);
		chk("clk_out_en in init", 32'h0, {31'h0, clk_out_en});
		rd(16'h00FE, 8'h0F, "ready after init");
		chk("clk_out_en run", 32'h1, {31'h0, clk_out_en});
		chk("freerun", 32'h1, {31'h0, freerun});
		rd(16'h00E2, 8'h00, "factory bank");
		rd(16'h05FE, 8'h0F, "ready other page");
		rd(16'h000B, 8'h5A, "factory bus addr");
		$display("Test power_up done");
	endtask

	task automatic t_divider;
		host_cmd(CMD_PREAMBLE, 16'h0000, 8'h00);
		rd(16'h0B24, 8'hC0, "guard1 pre");
		rd(16'h0B25, 8'h00, "guard2 pre");
		rd(16'h0540, 8'h01, "guard3 pre");
		wr(16'h0230, 8'h11);
		wr(16'h023F, 8'h22);
		host_cmd(CMD_POSTAMBLE, 16'h0000, 8'h00);
		chk("in_div applied", 32'h11, {24'h0, in_div});
		chk("xtal_div applied", 32'h22, {24'h0, xtal_div});
		chk("clk kept", 32'h1, {31'h0, clk_out_en});
		rd(16'h0540, 8'h00, "guard3 post");
		rd(16'h0B24, 8'hC3, "guard1 post");
		rd(16'h0B25, 8'h02, "guard2 post");
		rd(16'h0230, 8'h11, "no reload on soft");
		$display("Test divider_change done");
	endtask

	task automatic t_nvm;
		wr(16'h026B, 8'hA5);
		wr(16'h000B, 8'h33);
		host_cmd(CMD_NVM_LOAD, 16'h0000, 8'h00);
		rd(16'h00E2, 8'h01, "bank one");
		rd(16'h026B, 8'hA5, "scratch one");
		rd(16'h0230, 8'h11, "divider stored");
		rd(16'h000B, 8'h5A, "bus addr not stored");
		wr(16'h026B, 8'h3C);
		host_cmd(CMD_NVM_HARD, 16'h0000, 8'h00);
		rd(16'h00E2, 8'h02, "bank two");
		rd(16'h026B, 8'h3C, "scratch two");
		wr(16'h026B, 8'h77);
		host_cmd(CMD_NVM_LOAD, 16'h0000, 8'h00);
		rd(16'h00E2, 8'h02, "third burn refused");
		rd(16'h026B, 8'h3C, "old config kept");
		$display("Test nvm_program done");
	endtask

	task automatic t_hard;
		wr(16'h0230, 8'h99);
		wr(16'h001E, 8'h02);
		rd(16'h0230, 8'h11, "hard bit reload");
		rd(16'h00FE, 8'h0F, "ready after hard");
		wr(16'h0230, 8'h99);
		host_cmd(CMD_PIN, 16'h0000, 8'h00);
		rd(16'h0230, 8'h11, "pin reload");
		rd(16'h00E2, 8'h02, "bank after pin");
		$display("Test hard_reset done");
	endtask

	////////////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		miscompares = 0;
		check_count = 0;
		rst_n_in = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 4'h0;
		wb_sel = 4'h0;
		wb_dat_w = 32'h00000000;
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_power_up();
		t_divider();
		t_nvm();
		t_hard();
		summarize();
	end
endmodule

`default_nettype wire
